// File: ebc_port.sv
`timescale 1ns/10ps
// Functional notes
// - master drives 32-bit address for external, peripheral and peer accesses.
// - as slave, address bus is an input and goes to the target address without any decode.
// - 64-bit data bus, two-way, released when not driving.
// - master asserts read strobe for reads, never for sdram reads.
// - external read strobe reads internal memory or registers.
// - strobes and selects change in the same cycle as address.
// - low write strobe for even words, long words and 32-bit zones.
// - high write strobe for long words and odd words on 64-bit bus.
// - as slave, low and high write strobes mark lane writes.
// - as target, device drops acknowledge until it can complete.
// - boot select is boot chip select; sampled as strap on the first clock after internal reset releases.
// - bank selects decode address bits 31:27 as 00110 and 00111.
// - host space select asserted when address bit 31 is one.
// - current master asserts burst for consecutive addresses.
// - host burst accesses auto-increment internal target address.
// - only the bus master drives strobes and select outputs.
module ebc_port (
   input  wire logic                        ref_clk,
   input  wire logic                        arst_n,
   input  wire logic                        bus_master,
   // core-side master requests
   input  wire logic                        req_valid,
   output logic                             req_ready,
   input  wire ebc_pkg::ebc_req_s           req,
   output logic                             rsp_valid,
   output logic      [ebc_pkg::DATA_W-1:0]  rsp_data,
   // internal memory side for slave accesses
   output logic                             mem_rd,
   output logic                             mem_wr,
   output logic      [1:0]                  mem_lane_we,
   output logic      [ebc_pkg::ADDR_W-1:0]  mem_addr,
   output logic      [ebc_pkg::DATA_W-1:0]  mem_wdata,
   input  wire logic [ebc_pkg::DATA_W-1:0]  mem_rdata,
   input  wire logic                        mem_ready,
   output logic                             eprom_boot_strap,
   // address bus
   input  wire logic [ebc_pkg::ADDR_W-1:0]  address_bus_i,
   output logic      [ebc_pkg::ADDR_W-1:0]  address_bus_o,
   output logic                             address_bus_oe,
   // data bus
   input  wire logic [ebc_pkg::DATA_W-1:0]  data_bus_i,
   output logic      [ebc_pkg::DATA_W-1:0]  data_bus_o,
   output logic                             data_bus_oe,
   // strobes
   input  wire logic                        read_n_i,
   output logic                             read_n_o,
   output logic                             read_n_oe,
   input  wire logic                        write_low_word_n_i,
   output logic                             write_low_word_n_o,
   output logic                             write_low_word_n_oe,
   input  wire logic                        write_high_word_n_i,
   output logic                             write_high_word_n_o,
   output logic                             write_high_word_n_oe,
   // acknowledge, open drain
   input  wire logic                        ack_i,
   output logic                             ack_o,
   output logic                             ack_oe,
   // selects
   input  wire logic                        boot_memory_select_n_i,
   output logic                             boot_memory_select_n_o,
   output logic                             boot_memory_select_n_oe,
   output logic      [1:0]                  bank_select_n_o,
   output logic                             bank_select_n_oe,
   output logic                             host_space_select_n_o,
   output logic                             host_space_select_n_oe,
   // burst
   input  wire logic                        burst_flag_i,
   output logic                             burst_flag_o,
   output logic                             burst_flag_oe
);
   typedef enum logic [1:0] {EBC_IDLE, EBC_ACCESS} ebc_m_state_e;
   typedef enum logic [1:0] {EBC_S_IDLE, EBC_S_WAIT} ebc_s_state_e;

   logic                        rst_meta_reg;
   logic                        rst_n;
   ebc_m_state_e                m_state_reg;
   ebc_s_state_e                s_state_reg;
   ebc_pkg::ebc_req_s           cur_reg;
   logic                        strap_seen_reg;
   logic                        slave_rd;
   logic                        slave_wr;
   logic                        slave_hit;
   logic                        s_start;
   logic [ebc_pkg::ADDR_W-1:0]  s_addr;
   ebc_pkg::ebc_sel_s           sel;
   logic                        m_drive;
   logic                        s_rd_reg;
   logic [1:0]                  s_lane_reg;
   logic [ebc_pkg::DATA_W-1:0]  s_rdata_reg;
   logic                        s_rdata_oe_reg;
   logic                        s_burst_run_reg;

   // reset release through two flops; asserted asynchronously
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   // strap caught on the first clock after internal reset releases
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         strap_seen_reg   <= 1'b0;
         eprom_boot_strap <= 1'b0;
      end else if (!strap_seen_reg) begin
         strap_seen_reg   <= 1'b1;
         eprom_boot_strap <= boot_memory_select_n_i;
      end
   end

   // ---- master side ----
   assign req_ready = bus_master && (m_state_reg == EBC_IDLE);
   // only the owner drives; the pins float otherwise
   assign m_drive   = bus_master && (m_state_reg == EBC_ACCESS);

   // master access: hold everything until acknowledge is seen high
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         m_state_reg <= EBC_IDLE;
      end else begin
         case (m_state_reg)
            EBC_IDLE: begin
               if (req_valid && req_ready) begin
                  m_state_reg <= EBC_ACCESS;
               end
            end
            EBC_ACCESS: begin
               if (ack_i) begin
                  m_state_reg <= EBC_IDLE;
               end
            end
            default: begin
               m_state_reg <= EBC_IDLE;
            end
         endcase
      end
   end

   // latched request; address, strobes and selects all come from it together
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_reg <= '0;
      end else if (req_valid && req_ready) begin
         cur_reg <= req;
      end
   end

   // read data captured when the slave acknowledges
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_valid <= 1'b0;
         rsp_data  <= ebc_pkg::DATA_ZERO;
      end else begin
         rsp_valid <= (m_state_reg == EBC_ACCESS) && ack_i;
         if ((m_state_reg == EBC_ACCESS) && ack_i && (cur_reg.op == ebc_pkg::EBC_OP_READ)) begin
            rsp_data <= data_bus_i;
         end
      end
   end

   ebc_decode u_decode (
      .addr (cur_reg.addr),
      .sel  (sel)
   );

   // pin drive from the latched request, so all move in one cycle
   always_comb begin
      address_bus_o  = cur_reg.addr;
      address_bus_oe = m_drive;
      read_n_o = !(cur_reg.op == ebc_pkg::EBC_OP_READ && !cur_reg.sdram);
      write_low_word_n_o = !(cur_reg.op == ebc_pkg::EBC_OP_WRITE &&
         (cur_reg.zone32 || cur_reg.long_word || !cur_reg.addr[0]));
      write_high_word_n_o = !(cur_reg.op == ebc_pkg::EBC_OP_WRITE && !cur_reg.zone32 &&
         (cur_reg.long_word || cur_reg.addr[0]));
      read_n_oe              = m_drive;
      write_low_word_n_oe    = m_drive;
      write_high_word_n_oe   = m_drive;
      boot_memory_select_n_o = sel.boot_n;
      boot_memory_select_n_oe = m_drive;
      bank_select_n_o        = sel.bank_n;
      bank_select_n_oe       = m_drive;
      host_space_select_n_o  = sel.host_n;
      host_space_select_n_oe = m_drive;
      burst_flag_o           = !cur_reg.burst;
      burst_flag_oe          = m_drive;
   end

   // data bus: master write, or slave read return
   always_comb begin
      data_bus_o  = s_rdata_oe_reg ? s_rdata_reg : cur_reg.data;
      data_bus_oe = (m_drive && cur_reg.op == ebc_pkg::EBC_OP_WRITE) || s_rdata_oe_reg;
   end

   // ---- slave side ----
   // strobes from outside are only meaningful while someone else owns the bus
   assign slave_rd  = !bus_master && !read_n_i;
   assign slave_wr  = !bus_master && (!write_low_word_n_i || !write_high_word_n_i);
   assign slave_hit = slave_rd || slave_wr;
   assign s_start   = slave_hit && (s_state_reg == EBC_S_IDLE);

   // a burst run keeps the counter alive across transfers; only its first one loads it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_burst_run_reg <= 1'b0;
      end else if (bus_master || burst_flag_i) begin
         s_burst_run_reg <= 1'b0;
      end else if (s_start) begin
         s_burst_run_reg <= 1'b1;
      end
   end

   // burst counter follows the first address and steps on each completion
   ebc_slave_addr u_slave_addr (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .start    (s_start && !s_burst_run_reg),
      .addr_in  (address_bus_i),
      .step     ((s_state_reg == EBC_S_WAIT) && mem_ready),
      .burst    (!burst_flag_i),
      .addr_out (s_addr)
   );

   // slave holds acknowledge low until internal memory is ready
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_state_reg <= EBC_S_IDLE;
         s_rd_reg    <= 1'b0;
         s_lane_reg  <= 2'h0;
      end else begin
         case (s_state_reg)
            EBC_S_IDLE: begin
               if (slave_hit) begin
                  s_state_reg <= EBC_S_WAIT;
                  s_rd_reg    <= slave_rd;
                  s_lane_reg  <= {!write_high_word_n_i, !write_low_word_n_i};
               end
            end
            EBC_S_WAIT: begin
               if (mem_ready) begin
                  s_state_reg <= EBC_S_IDLE;
               end
            end
            default: begin
               s_state_reg <= EBC_S_IDLE;
            end
         endcase
      end
   end

   // slave read data held for one cycle after memory answers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_rdata_reg    <= ebc_pkg::DATA_ZERO;
         s_rdata_oe_reg <= 1'b0;
      end else begin
         s_rdata_oe_reg <= (s_state_reg == EBC_S_WAIT) && mem_ready && s_rd_reg;
         if ((s_state_reg == EBC_S_WAIT) && mem_ready) begin
            s_rdata_reg <= mem_rdata;
         end
      end
   end

   // acknowledge pulled low (open drain) while the slave waits
   always_comb begin
      ack_o       = 1'b0;
      ack_oe      = (s_state_reg == EBC_S_WAIT) && !mem_ready;
      mem_rd      = (s_state_reg == EBC_S_WAIT) && s_rd_reg;
      mem_wr      = (s_state_reg == EBC_S_WAIT) && !s_rd_reg;
      mem_lane_we = mem_wr ? s_lane_reg : 2'h0;
      mem_addr    = !burst_flag_i ? s_addr : address_bus_i;
      mem_wdata   = data_bus_i;
   end

   // master holds strobes through waits
   a_ack_stall: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (m_state_reg == EBC_ACCESS && !ack_i) |=> (m_state_reg == EBC_ACCESS))
      else $error("access ended while acknowledge low");
   a_bank0_decode: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (cur_reg.addr[ebc_pkg::BANK_HI:ebc_pkg::BANK_LO] == ebc_pkg::BANK0_CODE)
      |-> (bank_select_n_o == 2'h2))
      else $error("bank 0 select wrong");
   a_host_decode: assert property (@(posedge ref_clk) disable iff (!rst_n)
      host_space_select_n_o == !cur_reg.addr[ebc_pkg::HOST_BIT])
      else $error("host select wrong");
   a_no_sdram_rd: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (m_drive && cur_reg.sdram) |-> read_n_o)
      else $error("read strobe on sdram");
   a_float_slave: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !bus_master |-> !(address_bus_oe || read_n_oe || bank_select_n_oe))
      else $error("driving while not master");
   a_ack_target: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (s_state_reg == EBC_S_WAIT && !mem_ready) |-> ack_oe && !ack_o)
      else $error("acknowledge not held low");
   a_long_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (cur_reg.op == ebc_pkg::EBC_OP_WRITE && cur_reg.long_word && !cur_reg.zone32)
      |-> (!write_low_word_n_o && !write_high_word_n_o))
      else $error("long write lanes wrong");
   a_burst_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (s_state_reg == EBC_S_WAIT && mem_ready && !burst_flag_i && !s_start)
      |=> s_addr == $past(s_addr) + 32'h0000_0001)
      else $error("burst address did not step");

   // an accepted request brings the address, read, low write and bank drivers up in the next cycle
   sequence s_req_taken;
      (req_valid && req_ready) ##1 bus_master;
   endsequence
   sequence s_pins_driven;
      address_bus_oe && read_n_oe && write_low_word_n_oe && bank_select_n_oe;
   endsequence
   a_pins_together: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_req_taken |-> s_pins_driven)
      else $error("pins did not come up together");
   // read strobe for every non-sdram read, response as a single pulse
   a_read_strobe: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (m_drive && cur_reg.op == ebc_pkg::EBC_OP_READ && !cur_reg.sdram) |-> !read_n_o)
      else $error("read strobe missing");
   a_rsp_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rsp_valid |=> !rsp_valid)
      else $error("response longer than one cycle");
   // slave lanes follow the strobes seen when the access is taken
   a_lane_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (s_start && !slave_rd && !write_high_word_n_i) |=> mem_lane_we[1])
      else $error("high lane write missing");
   a_lane_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (s_start && !slave_rd && !write_low_word_n_i) |=> mem_lane_we[0])
      else $error("low lane write missing");
   // inside a burst run a new transfer keeps counting instead of reloading
   a_burst_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (s_start && s_burst_run_reg) |=> (s_addr == $past(s_addr)))
      else $error("burst address reloaded");
   // the strap is caught once and then held until the next reset
   a_strap_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      strap_seen_reg |=> $stable(eprom_boot_strap))
      else $error("boot strap changed after capture");
endmodule

// File: ebc_pkg.sv
package ebc_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 64;
   localparam int WORD_W = 32;
   localparam int BANK_HI = 31;
   localparam int BANK_LO = 27;
   localparam logic [4:0] BANK0_CODE = 5'h06;   // 0b00110
   localparam logic [4:0] BANK1_CODE = 5'h07;   // 0b00111
   localparam int HOST_BIT = 31;
   localparam int BOOT_HI = 31;
   localparam int BOOT_LO = 27;
   localparam logic [4:0] BOOT_CODE = 5'h01;    // boot window, arbitrary placement
   localparam logic [1:0] SEL_IDLE = 2'h3;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 32'h0000_0000;
   localparam logic [DATA_W-1:0] DATA_ZERO = 64'h0000_0000_0000_0000;

   typedef enum logic [1:0] {EBC_OP_READ, EBC_OP_WRITE} ebc_op_e;

   // one master access request from the core side
   typedef struct packed {
      ebc_op_e             op;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   data;
      logic                long_word;   // 64-bit write
      logic                zone32;      // target zone is a 32-bit bus
      logic                sdram;       // target is sdram: no read strobe
      logic                burst;
   } ebc_req_s;

   // decoded selects for the bus
   typedef struct packed {
      logic       boot_n;
      logic [1:0] bank_n;
      logic       host_n;
   } ebc_sel_s;
endpackage

// File: ebc_decode.sv
`timescale 1ns/10ps
// address-to-select decoder, purely combinational
module ebc_decode (
   input  wire logic [ebc_pkg::ADDR_W-1:0] addr,
   output ebc_pkg::ebc_sel_s               sel
);
   // selects are a pure function of the address so they move with it
   always_comb begin
      sel.bank_n = ebc_pkg::SEL_IDLE;
      sel.bank_n[0] = !(addr[ebc_pkg::BANK_HI:ebc_pkg::BANK_LO] == ebc_pkg::BANK0_CODE);
      sel.bank_n[1] = !(addr[ebc_pkg::BANK_HI:ebc_pkg::BANK_LO] == ebc_pkg::BANK1_CODE);
      sel.host_n = !addr[ebc_pkg::HOST_BIT];
      sel.boot_n = !(addr[ebc_pkg::BOOT_HI:ebc_pkg::BOOT_LO] == ebc_pkg::BOOT_CODE);
   end
endmodule

// File: ebc_slave_addr.sv
`timescale 1ns/10ps
// slave-side target address counter for burst accesses
module ebc_slave_addr (
   input  wire logic                        ref_clk,
   input  wire logic                        rst_n,
   input  wire logic                        start,
   input  wire logic [ebc_pkg::ADDR_W-1:0]  addr_in,
   input  wire logic                        step,
   input  wire logic                        burst,
   output logic      [ebc_pkg::ADDR_W-1:0]  addr_out
);
   // first transfer uses the bus address, later ones count while burst holds
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_out <= ebc_pkg::ADDR_ZERO;
      end else if (start) begin
         addr_out <= addr_in;
      end else if (step && burst) begin
         addr_out <= addr_out + 32'h0000_0001;
      end
   end
endmodule

// File: ebc_far_slave.sv
`timescale 1ns/10ps
// far-side slave memory that answers the device's own master accesses
module ebc_far_slave (
   input  wire logic        ref_clk,
   input  wire logic [3:0]  wait_cycles,
   input  wire logic [31:0] addr,
   input  wire logic        rd_n,
   input  wire logic        wr_lo_n,
   input  wire logic        wr_hi_n,
   output logic             ack_low,
   output logic             rdata_oe,
   output logic [63:0]      rdata
);
   logic [3:0] wait_cnt;
   logic       active;
   assign active = !rd_n || !wr_lo_n || !wr_hi_n;
   // count wait states; restarts once the strobes go away
   always_ff @(posedge ref_clk) begin
      if (!active) wait_cnt <= 4'h0;
      else if (wait_cnt != wait_cycles) wait_cnt <= wait_cnt + 4'h1;
   end
   // acknowledge pulled low until the wait count is reached
   assign ack_low = active && (wait_cnt != wait_cycles);
   // data only while the read strobe is low; it always follows the address now on the bus
   assign rdata_oe = !rd_n;
   assign rdata = {addr, ~addr};
endmodule

// File: external_bus_control_port_tb_top.sv
`timescale 1ns/10ps
module external_bus_control_port_tb_top;
   logic ref_clk = 1'b0, arst_n = 1'b0, bus_master = 1'b1, req_valid = 1'b0, mem_ready = 1'b0;
   ebc_pkg::ebc_req_s req = '0;
   logic req_ready, rsp_valid, mem_rd, mem_wr, strap, far_ack_low, far_oe;
   logic [1:0] mem_lane_we, bk_o;
   logic [31:0] mem_addr, a_o, a_in;
   logic [63:0] rsp_data, mem_wdata, d_o, d_in, far_d, mem_rdata = 64'h0;
   logic a_oe, d_oe, rd_o, rd_oe, wl_o, wl_oe, wh_o, wh_oe, ack_o, ack_oe, ack_in;
   logic bms_o, bms_oe, bms_in, bk_oe, hs_o, hs_oe, bf_o, bf_oe, rd_in, wl_in, wh_in, bf_in;
   // bench as external master; an idle strobe rests at its pull-up level
   logic h_oe = 1'b0, h_rd_n = 1'b1, h_wl_n = 1'b1, h_wh_n = 1'b1, h_bf_n = 1'b1, strap_drv = 1'b1;
   logic [31:0] h_addr = 32'h0;
   logic [63:0] h_data = 64'h0, float_pat = 64'h0;
   logic [3:0] wait_cycles = 4'h2;
   int miscompares = 0, checks = 0, cycles = 0;

   always #12.5 ref_clk = ~ref_clk;
   // an undriven data bus flips every cycle so a stale value never looks valid
   always @(posedge ref_clk) float_pat <= ~float_pat;
   assign a_in = a_oe ? a_o : h_oe ? h_addr : 32'hFFFF_FFFF;
   assign d_in = d_oe ? d_o : far_oe ? far_d : h_oe ? h_data : float_pat;
   assign rd_in = rd_oe ? rd_o : h_rd_n;
   assign wl_in = wl_oe ? wl_o : h_wl_n;
   assign wh_in = wh_oe ? wh_o : h_wh_n;
   assign bf_in = bf_oe ? bf_o : h_bf_n;
   assign bms_in = bms_oe ? bms_o : strap_drv;
   assign ack_in = !((ack_oe && !ack_o) || far_ack_low);

   ebc_port ebc_port_inst (
      .ref_clk(ref_clk), .arst_n(arst_n), .bus_master(bus_master), .req_valid(req_valid),
      .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_lane_we(mem_lane_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ready(mem_ready),
      .eprom_boot_strap(strap), .address_bus_i(a_in), .address_bus_o(a_o),
      .address_bus_oe(a_oe), .data_bus_i(d_in), .data_bus_o(d_o), .data_bus_oe(d_oe),
      .read_n_i(rd_in), .read_n_o(rd_o), .read_n_oe(rd_oe), .write_low_word_n_i(wl_in),
      .write_low_word_n_o(wl_o), .write_low_word_n_oe(wl_oe), .write_high_word_n_i(wh_in),
      .write_high_word_n_o(wh_o), .write_high_word_n_oe(wh_oe), .ack_i(ack_in),
      .ack_o(ack_o), .ack_oe(ack_oe), .boot_memory_select_n_i(bms_in),
      .boot_memory_select_n_o(bms_o), .boot_memory_select_n_oe(bms_oe),
      .bank_select_n_o(bk_o), .bank_select_n_oe(bk_oe), .host_space_select_n_o(hs_o),
      .host_space_select_n_oe(hs_oe), .burst_flag_i(bf_in), .burst_flag_o(bf_o),
      .burst_flag_oe(bf_oe));

   // the far slave only ever sees strobes that the device itself drives
   ebc_far_slave ebc_far_slave_inst (
      .ref_clk(ref_clk), .wait_cycles(wait_cycles), .addr(a_in),
      .rd_n(rd_oe ? rd_o : 1'b1), .wr_lo_n(wl_oe ? wl_o : 1'b1),
      .wr_hi_n(wh_oe ? wh_o : 1'b1), .ack_low(far_ack_low), .rdata_oe(far_oe), .rdata(far_d));

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish;
      if (miscompares == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // a hung handshake ends the run as a failure
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 4000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   task automatic do_reset;
      arst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      check("oe in reset", {a_oe, d_oe, rd_oe, wl_oe, wh_oe, ack_oe, bms_oe, bk_oe, hs_oe, bf_oe}, 0);
      @(posedge ref_clk) arst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      check("strap", strap, strap_drv);
   endtask

   // one master access; flags are long word, 32-bit zone, sdram, burst
   task automatic master(input ebc_pkg::ebc_op_e op, input logic [31:0] addr,
                         input logic [3:0] flags, input logic [3:0] pins, input logic [3:0] sel);
      ebc_pkg::ebc_req_s r;
      int n;
      r = {op, addr, {~addr, addr}, flags};
      @(posedge ref_clk);
      req <= r;
      req_valid <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (req_ready !== 1'b1 && n < 20);
      req_valid <= 1'b0;
      @(negedge ref_clk);
      check("address", a_o, addr);
      check("strobes", {rd_o, wl_o, wh_o, bf_o}, pins);
      check("selects", {bms_o, bk_o, hs_o}, sel);
      check("drivers", {a_oe, rd_oe, wl_oe, wh_oe, bk_oe, hs_oe, bms_oe, bf_oe, d_oe},
            {8'hFF, op == ebc_pkg::EBC_OP_WRITE});
      if (op == ebc_pkg::EBC_OP_WRITE) check("write data", d_o, {~addr, addr});
      @(negedge ref_clk);
      if (pins[3:1] != 3'h7)
         check("stall", {a_oe, a_o, rd_o, wl_o, wh_o}, {1'b1, addr, pins[3:1]});
      n = 0;
      while (rsp_valid !== 1'b1 && n < 20) begin
         @(negedge ref_clk);
         n++;
      end
      check("response", rsp_valid, 1'b1);
      if (pins[3] == 1'b0) check("read data", rsp_data, {addr, ~addr});
      @(posedge ref_clk);
   endtask

   task automatic master_reads;
      master(ebc_pkg::EBC_OP_READ, 32'h3000_0000, 4'h0, 4'h7, 4'hD);
      master(ebc_pkg::EBC_OP_READ, 32'h3800_0000, 4'h0, 4'h7, 4'hB);
      master(ebc_pkg::EBC_OP_READ, 32'h8000_0000, 4'h0, 4'h7, 4'hE);
      master(ebc_pkg::EBC_OP_READ, 32'h0800_0000, 4'h0, 4'h7, 4'h7);
      master(ebc_pkg::EBC_OP_READ, 32'h1000_0000, 4'h2, 4'hF, 4'hF);
      master(ebc_pkg::EBC_OP_READ, 32'h3000_0004, 4'h1, 4'h6, 4'hD);
   endtask

   task automatic master_writes;
      master(ebc_pkg::EBC_OP_WRITE, 32'h1000_0000, 4'h0, 4'hB, 4'hF);
      master(ebc_pkg::EBC_OP_WRITE, 32'h1000_0001, 4'h0, 4'hD, 4'hF);
      master(ebc_pkg::EBC_OP_WRITE, 32'h1000_0002, 4'h8, 4'h9, 4'hF);
      master(ebc_pkg::EBC_OP_WRITE, 32'h1000_0003, 4'h4, 4'hB, 4'hF);
   endtask

   task automatic not_master;
      @(posedge ref_clk) bus_master <= 1'b0;
      req_valid <= 1'b1;
      repeat (3) @(negedge ref_clk);
      check("ready", req_ready, 1'b0);
      check("released", {a_oe, d_oe, rd_oe, wl_oe, wh_oe, bms_oe, bk_oe, hs_oe, bf_oe}, 0);
      @(posedge ref_clk) req_valid <= 1'b0;
   endtask

   // external master access; lanes is {high, low} and zero means a read
   task automatic slave_access(input logic [1:0] lanes, input logic burst);
      @(posedge ref_clk);
      h_oe <= 1'b1;
      h_addr <= 32'h0000_0200;
      h_data <= 64'h1122_3344_5566_7788;
      h_rd_n <= (lanes != 2'h0);
      h_wl_n <= !lanes[0];
      h_wh_n <= !lanes[1];
      h_bf_n <= !burst;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      check("target address", mem_addr, 32'h0000_0200);
      check("access kind", {mem_rd, mem_wr}, {lanes == 2'h0, lanes != 2'h0});
      check("ack wait", ack_in, 1'b0);
      if (lanes != 2'h0) check("lanes", mem_lane_we, lanes);
      if (lanes != 2'h0) check("write data in", mem_wdata, h_data);
      @(posedge ref_clk);
      mem_ready <= 1'b1;
      mem_rdata <= 64'hA5A5_0F0F_C3C3_9696;
      h_addr <= 32'h0000_0FF0;
      @(posedge ref_clk) mem_ready <= 1'b0;
      // acknowledge is seen high here: a single access lets go, a burst holds on
      if (!burst) {h_rd_n, h_wl_n, h_wh_n, h_bf_n} <= 4'hF;
      @(negedge ref_clk);
      if (lanes == 2'h0) check("slave data oe", d_oe, 1'b1);
      if (lanes == 2'h0) check("slave data", d_o, mem_rdata);
      if (burst) check("burst step", mem_addr, 32'h0000_0201);
      if (burst) begin
         @(posedge ref_clk) mem_ready <= 1'b1;
         @(negedge ref_clk);
         check("burst second", {mem_rd, mem_addr}, {1'b1, 32'h0000_0201});
         @(posedge ref_clk) mem_ready <= 1'b0;
         {h_rd_n, h_wl_n, h_wh_n, h_bf_n} <= 4'hF;
      end
      @(posedge ref_clk);
      h_oe <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask

   initial begin
      do_reset();
      master_reads();
      master_writes();
      not_master();
      slave_access(2'h0, 1'b0);
      slave_access(2'h1, 1'b0);
      slave_access(2'h2, 1'b0);
      slave_access(2'h3, 1'b0);
      slave_access(2'h0, 1'b1);
      // second reset in mid-run with the strap the other way round
      strap_drv <= 1'b0;
      bus_master <= 1'b1;
      do_reset();
      master_reads();
      tally_and_finish();
   end
endmodule
